// ---- hdl/stat_pkg.sv ----
package stat_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned NUM_CNT = 3;

  // channel numbers of the three counters
  localparam int unsigned CH_UART = 0;
  localparam int unsigned CH_LOW  = 1;
  localparam int unsigned CH_HIGH = 2;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_UART_TX_HI  = 10'h271;
  localparam logic [9:0] IDX_UART_TX_LO  = 10'h272;
  localparam logic [9:0] IDX_LOW_TX_HI   = 10'h273;
  localparam logic [9:0] IDX_LOW_TX_LO   = 10'h274;
  localparam logic [9:0] IDX_HIGH_CMD_HI = 10'h275;
  localparam logic [9:0] IDX_HIGH_CMD_LO = 10'h276;
  localparam logic [9:0] IDX_CTRL        = 10'h27c;
  localparam logic [9:0] IDX_UART_SNAP   = 10'h27d;
  localparam logic [9:0] IDX_LOW_SNAP    = 10'h27e;
  localparam logic [9:0] IDX_HIGH_SNAP   = 10'h27f;

  localparam logic [15:0] CNT_SAT = 16'hffff;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // control register: bit n enables counting on channel n
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam logic [2:0]  CTRL_RST    = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } wr_state_e;

endpackage

// ---- hdl/stat_if.sv ----
`timescale 1ns/1ps
interface stat_if;
  logic        ev;
  logic        snap;
  logic [15:0] cnt;
  logic [15:0] latched;

  modport counter (
    input  ev,
    input  snap,
    output cnt,
    output latched
  );

  modport reader (
    output ev,
    output snap,
    input  cnt,
    input  latched
  );
endinterface

// ---- hdl/sat_stat_counter.sv ----
`timescale 1ns/1ps
module sat_stat_counter (
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  stat_if.counter    st
);

  // a frame that lands in the snapshot cycle opens the new interval
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.cnt <= stat_pkg::CNT_RST;
    end else if (st.snap) begin
      st.cnt <= st.ev ? stat_pkg::CNT_ONE : stat_pkg::CNT_RST;
    end else if (st.ev && st.cnt != stat_pkg::CNT_SAT) begin
      st.cnt <= st.cnt + stat_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.latched <= stat_pkg::CNT_RST;
    end else if (st.snap) begin
      st.latched <= st.cnt;
    end
  end

endmodule

// ---- hdl/link_frame_statistics_counters.sv ----
`timescale 1ns/1ps
// Operation
// - count every response frame sent over the host uart, sixteen bits.
// - uart transmit count holds at ffff instead of wrapping.
// - uart snapshot read latches the uart count and clears only the uart counter.
// - uart transmit count high byte at 0x271, low byte at 0x272.
// - low-side link count, high 0x273, low 0x274, read-only, reset 0.
// - high-side counts only error-free, valid-crc frames; saturates.
// - high-side valid count high byte at 0x275, read-only, reset zero.
// - its low byte at 0x276 pairs with the high byte.
module link_frame_statistics_counters (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        uart_tx_frame_i,
  input  wire logic        low_link_frame_i,
  input  wire logic        high_link_cmd_done_i,
  input  wire logic        high_link_crc_ok_i,
  input  wire logic        high_link_err_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  stat_pkg::rd_state_e rd_state_r;
  stat_pkg::wr_state_e wr_state_r;
  logic [2:0]          ctrl_r;
  logic [2:0]          ev_vec;
  logic [2:0]          snap_vec;
  logic                ar_hs;
  logic [9:0]          ar_idx;
  logic [31:0]         rd_word_nxt;
  logic [1:0]          rd_resp_nxt;
  logic                aw_have_r;
  logic                w_have_r;
  logic [9:0]          aw_idx_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                wr_go;
  logic [1:0]          wr_resp_nxt;
  logic [15:0]         lat_uart;
  logic [15:0]         lat_low;
  logic [15:0]         lat_high;

  stat_if st [stat_pkg::NUM_CNT] ();

  // ---------------- frame events ----------------
  always_comb begin
    ev_vec[stat_pkg::CH_UART] = uart_tx_frame_i
                              & ctrl_r[stat_pkg::CH_UART];
    ev_vec[stat_pkg::CH_LOW]  = low_link_frame_i
                              & ctrl_r[stat_pkg::CH_LOW];
    // frames with a bad crc or a link error never count
    ev_vec[stat_pkg::CH_HIGH] = high_link_cmd_done_i & high_link_crc_ok_i
                              & ~high_link_err_i
                              & ctrl_r[stat_pkg::CH_HIGH];
  end

  // ---------------- snapshot strobes ----------------
  assign ar_hs  = s_axi_arvalid_i & s_axi_arready_o;
  assign ar_idx = s_axi_araddr_i[11:2];

  always_comb begin
    snap_vec[stat_pkg::CH_UART] = ar_hs
                                && ar_idx == stat_pkg::IDX_UART_SNAP;
    snap_vec[stat_pkg::CH_LOW]  = ar_hs
                                && ar_idx == stat_pkg::IDX_LOW_SNAP;
    snap_vec[stat_pkg::CH_HIGH] = ar_hs
                                && ar_idx == stat_pkg::IDX_HIGH_SNAP;
  end

  for (genvar g = 0; g < stat_pkg::NUM_CNT; g++) begin : g_cnt
    assign st[g].ev   = ev_vec[g];
    assign st[g].snap = snap_vec[g];
    sat_stat_counter u_cnt (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .st     (st[g])
    );
  end

  assign lat_uart = st[stat_pkg::CH_UART].latched;
  assign lat_low  = st[stat_pkg::CH_LOW].latched;
  assign lat_high = st[stat_pkg::CH_HIGH].latched;

  // ---------------- read decode ----------------
  // software sees only the latched copies, so high and low bytes always
  // belong to the same interval whatever order they are read in
  always_comb begin
    rd_word_nxt = 32'h0000_0000;
    rd_resp_nxt = stat_pkg::RESP_OKAY;
    case (ar_idx)
      stat_pkg::IDX_UART_TX_HI:  rd_word_nxt[7:0] = lat_uart[15:8];
      stat_pkg::IDX_UART_TX_LO:  rd_word_nxt[7:0] = lat_uart[7:0];
      stat_pkg::IDX_LOW_TX_HI:   rd_word_nxt[7:0] = lat_low[15:8];
      stat_pkg::IDX_LOW_TX_LO:   rd_word_nxt[7:0] = lat_low[7:0];
      stat_pkg::IDX_HIGH_CMD_HI: rd_word_nxt[7:0] = lat_high[15:8];
      stat_pkg::IDX_HIGH_CMD_LO: rd_word_nxt[7:0] = lat_high[7:0];
      stat_pkg::IDX_CTRL:        rd_word_nxt[2:0] = ctrl_r;
      stat_pkg::IDX_UART_SNAP,
      stat_pkg::IDX_LOW_SNAP,
      stat_pkg::IDX_HIGH_SNAP:   rd_word_nxt = 32'h0000_0000;
      default:                   rd_resp_nxt = stat_pkg::RESP_DECERR;
    endcase
  end

  // ---------------- read channel ----------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_state_r      <= stat_pkg::RD_IDLE;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
    end else begin
      case (rd_state_r)
        stat_pkg::RD_IDLE: begin
          s_axi_arready_o <= 1'b1;
          if (ar_hs) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            rd_state_r      <= stat_pkg::RD_RESP;
          end
        end
        stat_pkg::RD_RESP: begin
          if (s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
            rd_state_r      <= stat_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_r      <= stat_pkg::RD_IDLE;
          s_axi_arready_o <= 1'b0;
          s_axi_rvalid_o  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= stat_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rdata_o <= rd_word_nxt;
      s_axi_rresp_o <= rd_resp_nxt;
    end
  end

  // ---------------- write channel ----------------
  // address and data are taken independently and held until both are in
  assign wr_go = aw_have_r & w_have_r & (wr_state_r == stat_pkg::WR_COLLECT);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_have_r       <= 1'b0;
      aw_idx_r        <= 10'h000;
      s_axi_awready_o <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      aw_have_r       <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end else if (!aw_have_r) begin
      s_axi_awready_o <= 1'b1;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_r       <= 1'b1;
        aw_idx_r        <= s_axi_awaddr_i[11:2];
        s_axi_awready_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w_have_r       <= 1'b0;
      wdata_r        <= 32'h0000_0000;
      wstrb_r        <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      w_have_r       <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end else if (!w_have_r) begin
      s_axi_wready_o <= 1'b1;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_r       <= 1'b1;
        wdata_r        <= s_axi_wdata_i;
        wstrb_r        <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
    end
  end

  // counter registers are read-only, so a write there is refused
  always_comb begin
    case (aw_idx_r)
      stat_pkg::IDX_CTRL:        wr_resp_nxt = stat_pkg::RESP_OKAY;
      stat_pkg::IDX_UART_TX_HI,
      stat_pkg::IDX_UART_TX_LO,
      stat_pkg::IDX_LOW_TX_HI,
      stat_pkg::IDX_LOW_TX_LO,
      stat_pkg::IDX_HIGH_CMD_HI,
      stat_pkg::IDX_HIGH_CMD_LO,
      stat_pkg::IDX_UART_SNAP,
      stat_pkg::IDX_LOW_SNAP,
      stat_pkg::IDX_HIGH_SNAP:   wr_resp_nxt = stat_pkg::RESP_SLVERR;
      default:                   wr_resp_nxt = stat_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_state_r     <= stat_pkg::WR_COLLECT;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= stat_pkg::RESP_OKAY;
    end else begin
      case (wr_state_r)
        stat_pkg::WR_COLLECT: begin
          if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_resp_nxt;
            wr_state_r     <= stat_pkg::WR_RESP;
          end
        end
        stat_pkg::WR_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            wr_state_r     <= stat_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_r     <= stat_pkg::WR_COLLECT;
          s_axi_bvalid_o <= 1'b0;
        end
      endcase
    end
  end

  // only byte lane 0 carries control bits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= stat_pkg::CTRL_RST;
    end else if (wr_go && aw_idx_r == stat_pkg::IDX_CTRL && wstrb_r[0]) begin
      ctrl_r <= wdata_r[stat_pkg::CTRL_EN_LSB +: 3];
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_uart_counts_frame: assert property (
    uart_tx_frame_i && ctrl_r[0] && !snap_vec[0]
      && st[0].cnt != stat_pkg::CNT_SAT
      |=> st[0].cnt == $past(st[0].cnt) + stat_pkg::CNT_ONE)
    else $error("uart frame not counted");

  a_uart_sat_hold: assert property (
    st[0].cnt == stat_pkg::CNT_SAT && !snap_vec[0]
      |=> st[0].cnt == stat_pkg::CNT_SAT)
    else $error("uart counter wrapped");

  a_snap_latch_clear: assert property (
    snap_vec[0]
      |=> st[0].latched == $past(st[0].cnt)
          && st[1].latched == $past(st[1].latched)
          && st[0].cnt == ($past(ev_vec[0]) ? stat_pkg::CNT_ONE
                                            : stat_pkg::CNT_RST))
    else $error("uart snapshot wrong");

  a_read_uart_hi: assert property (
    ar_hs && ar_idx == stat_pkg::IDX_UART_TX_HI
      |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h0, $past(lat_uart[15:8])})
    else $error("uart high byte read wrong");

  a_read_low_lo: assert property (
    ar_hs && ar_idx == stat_pkg::IDX_LOW_TX_LO
      |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h0, $past(lat_low[7:0])})
    else $error("low link low byte read wrong");

  a_high_bad_crc: assert property (
    high_link_cmd_done_i && (!high_link_crc_ok_i || high_link_err_i)
      && !snap_vec[2]
      |=> $stable(st[2].cnt))
    else $error("bad high link frame counted");

  a_read_high_hi: assert property (
    ar_hs && ar_idx == stat_pkg::IDX_HIGH_CMD_HI
      |=> s_axi_rresp_o == stat_pkg::RESP_OKAY
          && s_axi_rdata_o == {24'h0, $past(lat_high[15:8])})
    else $error("high link high byte read wrong");

  a_read_high_lo: assert property (
    ar_hs && ar_idx == stat_pkg::IDX_HIGH_CMD_LO
      |=> s_axi_rdata_o == {24'h0, $past(lat_high[7:0])})
    else $error("high link low byte read wrong");

  a_latch_stable: assert property (
    !snap_vec[2] ##1 !snap_vec[2] |=> $stable(st[2].latched)
      && $past(st[2].latched, 2) == st[2].latched)
    else $error("latched value moved without snapshot");

endmodule

// ---- verification/frame_src.sv ----
`timescale 1ns/1ps
module frame_src (
  input  wire logic clk_i,
  output logic      uart_o,
  output logic      low_o,
  output logic      done_o,
  output logic      crc_ok_o,
  output logic      err_o
);
  initial begin
    uart_o   = 1'b0;
    low_o    = 1'b0;
    done_o   = 1'b0;
    crc_ok_o = 1'b0;
    err_o    = 1'b0;
  end
  // m: bit0 uart, bit1 low link, bit2 high link done; held for n edges,
  // so one frame per edge keeps long counts short
  task automatic send(input logic [2:0] m, input logic ok,
                      input logic er, input int n);
    uart_o   <= m[0];
    low_o    <= m[1];
    done_o   <= m[2];
    crc_ok_o <= ok;
    err_o    <= er;
    repeat (n) @(posedge clk_i);
    uart_o   <= 1'b0;
    low_o    <= 1'b0;
    done_o   <= 1'b0;
    // qualifiers mean nothing without done: show the inverse, not the last
    crc_ok_o <= ~ok;
    err_o    <= ~er;
    @(posedge clk_i);
  endtask
endmodule

// ---- verification/link_frame_statistics_counters_test.sv ----
`timescale 1ns/1ps
module link_frame_statistics_counters_test;
  localparam logic [1:0] OK  = stat_pkg::RESP_OKAY;
  localparam logic [1:0] SE  = stat_pkg::RESP_SLVERR;
  localparam logic [1:0] DE  = stat_pkg::RESP_DECERR;
  localparam logic [9:0] UHI = stat_pkg::IDX_UART_TX_HI;
  localparam logic [9:0] LHI = stat_pkg::IDX_LOW_TX_HI;
  localparam logic [9:0] HHI = stat_pkg::IDX_HIGH_CMD_HI;
  localparam logic [9:0] CTL = stat_pkg::IDX_CTRL;
  localparam logic [9:0] USN = stat_pkg::IDX_UART_SNAP;
  localparam logic [9:0] LSN = stat_pkg::IDX_LOW_SNAP;
  localparam logic [9:0] HSN = stat_pkg::IDX_HIGH_SNAP;
  logic        clk, rstn, uart, low, done, crc_ok, err;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          errors, cmp_count;

  frame_src u_src (
    .clk_i   (clk),
    .uart_o  (uart),
    .low_o   (low),
    .done_o  (done),
    .crc_ok_o(crc_ok),
    .err_o   (err)
  );

  link_frame_statistics_counters u_dut (
    .clk_i               (clk),
    .rstn_i              (rstn),
    .uart_tx_frame_i     (uart),
    .low_link_frame_i    (low),
    .high_link_cmd_done_i(done),
    .high_link_crc_ok_i  (crc_ok),
    .high_link_err_i     (err),
    .s_axi_awaddr_i      (awaddr),
    .s_axi_awvalid_i     (awvalid),
    .s_axi_awready_o     (awready),
    .s_axi_wdata_i       (wdata),
    .s_axi_wstrb_i       (wstrb),
    .s_axi_wvalid_i      (wvalid),
    .s_axi_wready_o      (wready),
    .s_axi_bresp_o       (bresp),
    .s_axi_bvalid_o      (bvalid),
    .s_axi_bready_i      (bready),
    .s_axi_araddr_i      (araddr),
    .s_axi_arvalid_i     (arvalid),
    .s_axi_arready_o     (arready),
    .s_axi_rdata_o       (rdata),
    .s_axi_rresp_o       (rresp),
    .s_axi_rvalid_o      (rvalid),
    .s_axi_rready_i      (rready)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(inout int t);
    @(posedge clk);
    t++;
    if (t > 60) begin
      errors++;
      $display("BAD handshake expected answer seen none");
      complete_run();
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d,
                    input logic [1:0] er);
    int   t;
    logic got;
    t = 0;
    got = 1'b0;
    awaddr  <= {i, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got) begin
      tick(t);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk($sformatf("bresp %h", i), {30'h0, er}, {30'h0, bresp});
      end
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] e,
                    input logic [1:0] er);
    int   t;
    logic got;
    t = 0;
    got = 1'b0;
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got) begin
      tick(t);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        chk($sformatf("rdata %h", i), e, rdata);
        chk($sformatf("rresp %h", i), {30'h0, er}, {30'h0, rresp});
      end
    end
    @(posedge clk);
  endtask

  // snapshot read, then both bytes of the latched pair
  task automatic snapc(input logic [9:0] s, input logic [9:0] h,
                       input logic [15:0] e);
    rd(s, 32'h0, OK);
    rd(h, {24'h0, e[15:8]}, OK);
    rd(h + 10'h1, {24'h0, e[7:0]}, OK);
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    rstn = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      rd(UHI + k[9:0], 32'h0, OK);
    end
    rd(CTL, 32'h7, OK);
    wr(UHI, 32'h5a, SE);
    wr(HHI, 32'h5a, SE);
    wr(USN, 32'h0, SE);
    rd(HHI, 32'h0, OK);
    rd(10'h0, 32'h0, DE);
    wr(10'h0, 32'h1, DE);
    $display("test reset_map done");
    u_src.send(3'b001, 1'b1, 1'b0, 5);
    u_src.send(3'b010, 1'b1, 1'b0, 3);
    u_src.send(3'b100, 1'b1, 1'b0, 4);
    u_src.send(3'b100, 1'b0, 1'b0, 2);
    u_src.send(3'b100, 1'b1, 1'b1, 2);
    rd(UHI + 10'h1, 32'h0, OK);
    snapc(USN, UHI, 16'h0005);
    snapc(LSN, LHI, 16'h0003);
    snapc(HSN, HHI, 16'h0004);
    $display("test count_filter done");
    u_src.send(3'b111, 1'b1, 1'b0, 2);
    rd(UHI + 10'h1, 32'h5, OK);
    snapc(USN, UHI, 16'h0002);
    snapc(LSN, LHI, 16'h0002);
    snapc(HSN, HHI, 16'h0002);
    wr(CTL, 32'h0, OK);
    u_src.send(3'b111, 1'b1, 1'b0, 3);
    snapc(USN, UHI, 16'h0000);
    snapc(LSN, LHI, 16'h0000);
    snapc(HSN, HHI, 16'h0000);
    wr(CTL, 32'h7, OK);
    rd(CTL, 32'h7, OK);
    // lane 0 strobe off: the control write is answered but changes nothing
    wstrb <= 4'he;
    wr(CTL, 32'h0, OK);
    rd(CTL, 32'h7, OK);
    wstrb <= 4'hf;
    // a frame in the snapshot cycle belongs to the new interval
    fork
      u_src.send(3'b001, 1'b1, 1'b0, 3);
      rd(USN, 32'h0, OK);
    join
    snapc(USN, UHI, 16'h0003);
    $display("test restart done");
    u_src.send(3'b111, 1'b1, 1'b0, 65537);
    snapc(USN, UHI, 16'hffff);
    snapc(LSN, LHI, 16'hffff);
    snapc(HSN, HHI, 16'hffff);
    $display("test saturate done");
    wr(CTL, 32'h0, OK);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(CTL, 32'h7, OK);
    rd(HHI, 32'h0, OK);
    rd(LHI + 10'h1, 32'h0, OK);
    rd(UHI, 32'h0, OK);
    $display("test reset_again done");
    complete_run();
  end
endmodule
